//--- design/eeprom_two_wire_read_write.sv
`timescale 1ns/1ps
`include "eeprom_cfg.svh"
module eeprom_two_wire_read_write #(
  parameter int unsigned WR_CYCLES = `WR_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic select_pin_high_i,
  input wire logic select_pin_mid_i,
  input wire logic select_pin_low_i,
  input wire logic hv_i,
  output logic write_busy_o,
  output logic half_select_o
);
  import eeprom_pkg::*;

  localparam int NP = 6;
  localparam int TW = $clog2(WR_CYCLES + 1);

  // Reset carried into the link domain
  logic lrst_a_q;
  logic lrst_n_q;
  always_ff @(posedge link_clk_i)
  begin
    lrst_a_q <= rst_n_i;
    lrst_n_q <= lrst_a_q;
  end

  // Pins: three flops, a change counts once the last two agree
  wire [NP-1:0] pin_raw = {hv_i, select_pin_high_i, select_pin_mid_i, select_pin_low_i, sda_i, scl_i};
  wire [NP-1:0] pin_f;
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++)
    begin : g_pin
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic f_q;
      always_ff @(posedge link_clk_i)
      begin
        s1_q <= pin_raw[gi];
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (!lrst_n_q)
          f_q <= 1'b1;
        else if (s2_q == s3_q)
          f_q <= s3_q;
      end
      assign pin_f[gi] = f_q;
    end
  endgenerate

  wire scl_f = pin_f[0];
  wire sda_f = pin_f[1];
  wire [2:0] sel_f = pin_f[4:2];
  wire hv_f = pin_f[5];

  logic scl_p_q;
  logic sda_p_q;
  link_state_t state_q;
  cmd_kind_t ck_q;
  logic [3:0] cnt_q;
  logic ack_q;
  logic oe_q;
  logic hok_q;
  logic [7:0] sr_q;
  logic [7:0] tx_q;
  logic [7:0] addr_q;
  logic [4:0] page_q;
  logic half_q;
  logic hs_q;
  logic [1:0] cq_q;
  logic [3:0] prot_q;
  logic [4:0] nb_q;
  logic wp_q;
  logic [15:0] mask_q;
  logic commit_q;
  logic [4:0] cidx_q;
  logic req_tg_q;
  logic dn1_q;
  logic dn2_q;
  logic done_tg_q;
  logic [7:0] rd_data;
  logic [7:0] buf_data;

  wire scl_rise = scl_f & ~scl_p_q;
  wire scl_fall = ~scl_f & scl_p_q;
  wire start_c = scl_f & scl_p_q & sda_p_q & ~sda_f;
  wire stop_c = scl_f & scl_p_q & ~sda_p_q & sda_f;
  wire byte_done = scl_fall & (cnt_q == 4'd8) & ~ack_q;
  wire ack_fall = scl_fall & ack_q;
  wire rd_load = ack_fall & (state_q == ST_RDATA) & hok_q;
  wire busy = (req_tg_q != dn2_q) | commit_q;

  // Device byte decode
  wire [2:0] m_id = sr_q[3:1];
  wire mem_hit = (sr_q[7:4] == `DEV_TYPE) && (sr_q[3:1] == sel_f);
  wire cmd_hit = (sr_q[7:4] == `CMD_TYPE) && !sr_q[0];
  wire half_hit = cmd_hit && (sr_q[3:2] == `HALF_PREFIX);
  wire clr_hit = cmd_hit && hv_f && (m_id == `CLEAR_ID);
  wire q_valid = (m_id == `QUAD0_ID) || (m_id == `QUAD1_ID) || (m_id == `QUAD2_ID) || (m_id == `QUAD3_ID);
  wire [1:0] q_idx = (m_id == `QUAD1_ID) ? 2'd1 : (m_id == `QUAD2_ID) ? 2'd2 : (m_id == `QUAD3_ID) ? 2'd3 : 2'd0;
  wire set_hit = cmd_hit && hv_f && q_valid;
  wire set_prot = set_hit && prot_q[q_idx];
  wire dev_ok = !busy && (mem_hit || half_hit || clr_hit || (set_hit && !prot_q[q_idx])); // R13 R19
  // Quadrant of the write target from half select and word address bit 7
  wire wr_prot = prot_q[{half_q, addr_q[7]}]; // R22
  wire ack_go = (state_q == ST_DEV) ? dev_ok :
                (state_q == ST_WADDR) || (state_q == ST_CMD) ? 1'b1 :
                (state_q == ST_WDATA) ? !wr_prot : 1'b0; // R10 R16 R18
  wire buf_we = byte_done && (state_q == ST_WDATA) && ack_go;
  // The 10th clock's rise has already shifted one bit in when its Stop arrives
  wire wr_go = stop_c && (state_q == ST_WDATA) && (cnt_q == 4'd1) && (nb_q != 5'd0) && !wp_q; // R11
  wire cmd_go = stop_c && (state_q == ST_CMD) && (cnt_q == 4'd1) && (nb_q != 5'd0);
  wire cyc_go = wr_go || (cmd_go && (ck_q != CK_HALF)); // R19
  wire [3:0] lidx = cidx_q[3:0] - 4'h1;
  wire mem_we = commit_q && (cidx_q != 5'd0) && mask_q[lidx];

  always_ff @(posedge link_clk_i)
  begin
    scl_p_q <= scl_f;
    sda_p_q <= sda_f;
    dn1_q <= done_tg_q;
    dn2_q <= dn1_q;
  end

  // Protocol engine; Start and Stop outrank clock edges
  always_ff @(posedge link_clk_i)
  begin
    if (!lrst_n_q)
    begin
      state_q <= ST_IDLE;
      ck_q <= CK_HALF;
      cnt_q <= 4'd0;
      ack_q <= 1'b0;
      oe_q <= 1'b0;
      hok_q <= 1'b0;
      sr_q <= 8'h00;
      tx_q <= 8'h00;
      addr_q <= 8'h00;
      page_q <= 5'h00;
      half_q <= `HALF_RESET; // R21
      hs_q <= 1'b0;
      cq_q <= 2'd0;
      prot_q <= 4'h0;
      nb_q <= 5'd0;
      wp_q <= 1'b0;
      mask_q <= 16'h0000;
      commit_q <= 1'b0;
      cidx_q <= 5'd0;
      req_tg_q <= 1'b0;
    end
    else
    begin
      if (commit_q)
      begin
        cidx_q <= cidx_q + 5'd1;
        commit_q <= (cidx_q != 5'd16);
      end
      if (start_c)
      begin
        state_q <= ST_DEV;
        cnt_q <= 4'd0;
        ack_q <= 1'b0;
        oe_q <= 1'b0;
      end
      else if (stop_c)
      begin
        // Stop away from the 10th clock discards the loaded page
        if (wr_go)
        begin
          commit_q <= 1'b1;
          cidx_q <= 5'd0;
        end
        if (cmd_go)
        begin
          unique case (ck_q)
            CK_HALF: half_q <= hs_q;
            CK_SET: prot_q[cq_q] <= 1'b1;
            CK_CLR: prot_q <= 4'h0;
          endcase
        end
        if (cyc_go)
          req_tg_q <= ~req_tg_q; // R11 R12
        state_q <= ST_IDLE;
        ack_q <= 1'b0;
        oe_q <= 1'b0;
      end
      else if (scl_rise)
      begin
        if (!ack_q && cnt_q < 4'd8)
        begin
          sr_q <= {sr_q[6:0], sda_f};
          cnt_q <= cnt_q + 4'd1;
        end
        else if (ack_q && state_q == ST_RDATA)
          hok_q <= ~sda_f; // R07
      end
      else if (byte_done)
      begin
        ack_q <= 1'b1;
        oe_q <= ack_go; // R01 R09 R10 R13
        unique case (state_q)
          ST_DEV:
          begin
            if (!ack_go)
              state_q <= ST_IGNORE;
            else if (mem_hit)
              state_q <= sr_q[0] ? ST_RDATA : ST_WADDR; // R06
            else
              state_q <= ST_CMD;
            ck_q <= half_hit ? CK_HALF : clr_hit ? CK_CLR : CK_SET;
            cq_q <= q_idx;
            hs_q <= sr_q[1];
            nb_q <= 5'd0;
          end
          ST_WADDR:
          begin
            addr_q <= sr_q; // R09
            page_q <= {half_q, sr_q[7:4]};
            nb_q <= 5'd0;
            wp_q <= 1'b0;
            mask_q <= 16'h0000;
            state_q <= ST_WDATA;
          end
          ST_WDATA:
          begin
            if (ack_go)
            begin
              mask_q[addr_q[3:0]] <= 1'b1;
              addr_q[3:0] <= addr_q[3:0] + 4'h1; // R15 R17
              if (nb_q != 5'd16)
                nb_q <= nb_q + 5'd1;
            end
            else
              wp_q <= 1'b1; // R18
          end
          ST_CMD:
          begin
            if (nb_q != 5'd16)
              nb_q <= nb_q + 5'd1;
          end
          ST_IDLE, ST_RDATA, ST_IGNORE:
          begin
          end
        endcase
      end
      else if (ack_fall)
      begin
        ack_q <= 1'b0;
        cnt_q <= 4'd0;
        oe_q <= 1'b0;
        if (state_q == ST_RDATA)
        begin
          if (hok_q)
          begin
            tx_q <= rd_data; // R02
            oe_q <= ~rd_data[7];
            addr_q <= addr_q + 8'h01; // R03 R04 R08
          end
          else
            state_q <= ST_IGNORE; // R05
        end
      end
      else if (scl_fall && state_q == ST_RDATA && cnt_q != 4'd0)
      begin
        tx_q <= {tx_q[6:0], 1'b0};
        oe_q <= ~tx_q[6];
      end
    end
  end

  // Page buffer holds data until a valid Stop commits it
  eeprom_mem #(.DW(8), .AW(4)) u_page (
    .clk_i(link_clk_i),
    .we_i(buf_we),
    .waddr_i(addr_q[3:0]),
    .wdata_i(sr_q),
    .raddr_i(cidx_q[3:0]),
    .rdata_o(buf_data)
  );

  eeprom_mem #(.DW(8), .AW(9)) u_array (
    .clk_i(link_clk_i),
    .we_i(mem_we),
    .waddr_i({page_q, lidx}),
    .wdata_i(buf_data),
    .raddr_i({half_q, addr_q}), // R20
    .rdata_o(rd_data)
  );

  assign sda_o = 1'b0;
  assign sda_oe_o = oe_q;
  assign half_select_o = half_q;

  // Write cycle timer; fixed length whatever the byte count
  logic r1_q;
  logic r2_q;
  logic r3_q;
  logic busy_q;
  logic [TW-1:0] tcnt_q;
  wire req_ev = r2_q ^ r3_q;

  always_ff @(posedge clk_i)
  begin
    r1_q <= req_tg_q;
    r2_q <= r1_q;
    r3_q <= r2_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      busy_q <= 1'b0;
      done_tg_q <= 1'b0;
      tcnt_q <= '0;
    end
    else if (req_ev)
    begin
      busy_q <= 1'b1;
      tcnt_q <= TW'(WR_CYCLES - 1); // R12
    end
    else if (busy_q)
    begin
      if (tcnt_q == '0)
      begin
        busy_q <= 1'b0;
        done_tg_q <= ~done_tg_q;
      end
      else
        tcnt_q <= tcnt_q - 1'b1;
    end
  end

  assign write_busy_o = busy_q;

  property p_read_ack;
    @(posedge link_clk_i) disable iff (!lrst_n_q)
    byte_done && state_q == ST_DEV && !busy && sr_q == {`DEV_TYPE, sel_f, 1'b1} |=> oe_q && state_q == ST_RDATA;
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("read address not acked"); // R01

  property p_write_ack;
    @(posedge link_clk_i) disable iff (!lrst_n_q)
    byte_done && state_q == ST_DEV && !busy && sr_q == {`DEV_TYPE, sel_f, 1'b0} |=> oe_q ##0 state_q == ST_WADDR;
  endproperty
  a_write_ack: assert property (p_write_ack) else $error("write address not acked"); // R09

  property p_busy_nack;
    @(posedge link_clk_i) disable iff (!lrst_n_q)
    byte_done && state_q == ST_DEV && busy |=> (!oe_q) [*2];
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("acked while writing"); // R13

  property p_prot_nack;
    @(posedge link_clk_i) disable iff (!lrst_n_q)
    byte_done && state_q == ST_WDATA && wr_prot |=> !oe_q && wp_q && $stable(mask_q);
  endproperty
  a_prot_nack: assert property (p_prot_nack) else $error("protected data acked"); // R18

  property p_set_prot;
    @(posedge link_clk_i) disable iff (!lrst_n_q)
    byte_done && state_q == ST_DEV && set_prot && !mem_hit |=> !oe_q && state_q == ST_IGNORE;
  endproperty
  a_set_prot: assert property (p_set_prot) else $error("set on protected quadrant acked"); // R19

  property p_bad_stop;
    @(posedge link_clk_i) disable iff (!lrst_n_q)
    stop_c && state_q == ST_WDATA && cnt_q != 4'd1 |=> $stable(req_tg_q) && !commit_q;
  endproperty
  a_bad_stop: assert property (p_bad_stop) else $error("write started on misplaced stop"); // R11

  property p_page_inc;
    @(posedge link_clk_i) disable iff (!lrst_n_q)
    buf_we |=> addr_q[7:4] == $past(addr_q[7:4]) && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1;
  endproperty
  a_page_inc: assert property (p_page_inc) else $error("page address step wrong"); // R15 R17

  property p_read_load;
    @(posedge link_clk_i) disable iff (!lrst_n_q)
    rd_load |=> addr_q == $past(addr_q) + 8'h01 && oe_q == !tx_q[7];
  endproperty
  a_read_load: assert property (p_read_load) else $error("read byte or counter wrong"); // R02 R04

  property p_timer;
    @(posedge clk_i) disable iff (!rst_n_i)
    req_ev |=> busy_q && tcnt_q == TW'(WR_CYCLES - 1);
  endproperty
  a_timer: assert property (p_timer) else $error("write timer not loaded"); // R12

  c_commit: cover property (@(posedge link_clk_i) disable iff (!lrst_n_q) wr_go);
  c_seq_read: cover property (@(posedge link_clk_i) disable iff (!lrst_n_q) rd_load && addr_q == 8'hff);
  c_poll_nack: cover property (@(posedge link_clk_i) disable iff (!lrst_n_q) byte_done && state_q == ST_DEV && busy);
  c_prot: cover property (@(posedge link_clk_i) disable iff (!lrst_n_q) byte_done && state_q == ST_WDATA && wr_prot);
endmodule

//--- design/eeprom_cfg.svh
// Functional notes
// R01: Read opens with 1010, select pins, read bit
// R02: Current read acks then sends counter byte MSB-first
// R03: Word counter holds last access plus one
// R04: Read counter wraps inside the selected half
// R05: Host ends read with NACK then Stop
// R06: Random read: dummy write, restart, then read
// R07: Host ACK means increment and send next byte
// R08: Sequential read FFh continues at 00h same half
// R09: Write device byte acked, next is word address
// R10: Word address and each data byte acked
// R11: Write cycle only on Stop at 10th clock
// R12: Write cycle time fixed, independent of byte count
// R13: Busy writing: no address byte acknowledged
// R14: Host waits write time or polls for ACK
// R15: Counter advances once per written data byte
// R16: Up to sixteen data bytes per page write
// R17: Page write advances low nibble only, wraps page
// R18: Protected quadrant: data NACKed, no write cycle
// R19: Set on protected quadrant fully NACKed, else acked
// R20: Half select picks lower or upper 256 bytes
// R21: Half select cleared at power-up
// R22: One protect flag per quadrant, checked before writing
`ifndef EEPROM_CFG_SVH
`define EEPROM_CFG_SVH

`define DEV_TYPE 4'ha
`define CMD_TYPE 4'h6
`define HALF_PREFIX 2'b11
`define QUAD0_ID 3'b001
`define QUAD1_ID 3'b100
`define QUAD2_ID 3'b101
`define QUAD3_ID 3'b000
`define CLEAR_ID 3'b011
`define HALF_RESET 1'b0
`define PAGE_BYTES 16
`define WRITE_CYCLE_TIME_US 5000
`define CLK_MHZ 250
`define WR_CYCLES (`WRITE_CYCLE_TIME_US * `CLK_MHZ)

`endif

//--- design/eeprom_pkg.sv
package eeprom_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_DEV, ST_WADDR, ST_WDATA, ST_RDATA, ST_CMD, ST_IGNORE} link_state_t;
  typedef enum logic [1:0] {CK_HALF, CK_SET, CK_CLR} cmd_kind_t;
endpackage

//--- design/eeprom_mem.sv
`timescale 1ns/1ps
module eeprom_mem #(
  parameter int DW = 8,
  parameter int AW = 9
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [DW-1:0] rdata_o
);
  logic [DW-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clk_i)
  begin
    if (we_i)
    begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule

//--- test/two_wire_host.sv
`timescale 1ns/1ps
module two_wire_host (
  input wire logic lclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_low_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  // Half period of 10 link cycles keeps every level past the device's synchroniser
  task automatic gap(input int n);
    repeat (n) @(posedge lclk_i);
    #1;
  endtask

  // Also serves as a repeated start from SCL low
  task automatic start();
    sda_low_o = 1'b0;
    gap(5);
    scl_o = 1'b1;
    gap(5);
    sda_low_o = 1'b1;
    gap(5);
    scl_o = 1'b0;
  endtask

  task automatic stop();
    gap(5);
    sda_low_o = 1'b1;
    gap(5);
    scl_o = 1'b1;
    gap(5);
    sda_low_o = 1'b0;
    gap(10);
  endtask

  task automatic bit_x(input logic b, output logic r);
    gap(5);
    sda_low_o = ~b;
    gap(5);
    scl_o = 1'b1;
    gap(5);
    r = sda_i;
    gap(5);
    scl_o = 1'b0;
  endtask

  task automatic wr_byte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(v[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // A last byte is refused by the host before its stop
  task automatic rd_byte(input logic more, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_x(1'b1, v[i]);
    bit_x(~more, r);
  endtask
endmodule

//--- test/tb_eeprom_two_wire_read_write.sv
`timescale 1ns/1ps
module tb_eeprom_two_wire_read_write;
  localparam int WR = 1000;
  logic clk_i = 1'b0;
  logic lclk = 1'b0;
  logic rst_n_i = 1'b0;
  logic hv = 1'b0;
  logic hx = 1'b0;
  logic [2:0] pins = 3'h0;
  logic scl, sda, sda_low, sda_o, sda_oe, busy, half, a;
  logic [7:0] d;
  logic [7:0] mem [512];
  int failures = 0;
  int comparisons = 0;
  int bcnt = 0;
  int bp, t, t2;

  always #2 clk_i = ~clk_i;
  initial #1.3 forever #6 lclk = ~lclk;
  // Open-drain wire with pull-up
  assign sda = ~((sda_oe & ~sda_o) | sda_low);
  always @(posedge clk_i) if (busy === 1'b1) bcnt <= bcnt + 1;

  eeprom_two_wire_read_write #(.WR_CYCLES(WR)) eeprom_two_wire_read_write_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .link_clk_i(lclk), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
    .select_pin_high_i(pins[2]), .select_pin_mid_i(pins[1]), .select_pin_low_i(pins[0]),
    .hv_i(hv), .write_busy_o(busy), .half_select_o(half));
  two_wire_host two_wire_host_i (.lclk_i(lclk), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));

  task automatic check(input logic [8:0] seen, input logic [8:0] exp, input string m);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t %s: got %h want %h", $time, m, seen, exp);
    end
  endtask

  function automatic logic [7:0] dev(input logic rw);
    return {4'ha, pins, rw};
  endfunction

  task automatic send(input logic [7:0] b, input logic e, input string m);
    two_wire_host_i.wr_byte(b, a);
    check(a, e, m);
  endtask

  task automatic poll();
    t = 0;
    do
    begin
      two_wire_host_i.start();
      two_wire_host_i.wr_byte(dev(1'b0), a);
      two_wire_host_i.stop();
      t++;
    end while (a !== 1'b1 && t < 20);
    check(a, 1'b1, "poll ack");
    check(t > 1, 1'b1, "busy nack");
  endtask

  task automatic setaddr(input logic [7:0] ad);
    two_wire_host_i.start();
    send(dev(1'b0), 1'b1, "dev wr");
    send(ad, 1'b1, "word addr");
  endtask

  task automatic wr_page(input logic [7:0] ad, input int n, output int bw);
    logic [7:0] v;
    setaddr(ad);
    for (int i = 0; i < n; i++)
    begin
      v = 8'($urandom);
      send(v, 1'b1, "data ack");
      mem[{hx, ad[7:4], ad[3:0] + 4'(i)}] = v;
    end
    // Cleared before Stop so that the first busy cycle is counted
    bcnt = 0;
    two_wire_host_i.stop();
    poll();
    bw = bcnt;
  endtask

  task automatic cur(input logic [7:0] ad, input int n);
    logic [7:0] p;
    two_wire_host_i.start();
    send(dev(1'b1), 1'b1, "dev rd");
    for (int i = 0; i < n; i++)
    begin
      p = ad + 8'(i);
      two_wire_host_i.rd_byte(i < n - 1, d);
      check(d, mem[{hx, p}], "read data");
    end
    two_wire_host_i.stop();
  endtask

  task automatic rd_seq(input logic [7:0] ad, input int n);
    setaddr(ad);
    cur(ad, n);
  endtask

  task automatic cmd(input logic [7:0] c, input logic e);
    two_wire_host_i.start();
    send(c, e, "cmd");
    send(8'($urandom), e, "cmd byte 1");
    send(8'($urandom), e, "cmd byte 2");
    two_wire_host_i.stop();
    repeat (20) @(posedge lclk);
  endtask

  task automatic quiet();
    bcnt = 0;
    repeat (200) @(posedge clk_i);
    check(bcnt == 0, 1'b1, "no write cycle");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    void'($urandom(32'h61ba2dba));
    pins = 3'($urandom);
    // Longer than two cycles so the link domain sees the reset too
    repeat (16) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    repeat (10) @(posedge lclk);
    check(half, 1'b0, "half reset");
    two_wire_host_i.start();
    send({4'ha, ~pins, 1'b1}, 1'b0, "foreign pins");
    two_wire_host_i.stop();
    $display("test addressing done");
    wr_page(8'h30, 18, bp);
    rd_seq(8'h30, 4);
    cur(8'h34, 1);
    wr_page(8'h00, 2, t2);
    wr_page(8'h00, 1, t2);
    cur(8'h01, 1);
    wr_page(8'hff, 1, t2);
    check(t2 == bp, 1'b1, "cycle length");
    check(bp == WR, 1'b1, "cycle time");
    rd_seq(8'hff, 3);
    $display("test read write done");
    setaddr(8'h01);
    send(8'($urandom), 1'b1, "data ack");
    repeat (4) two_wire_host_i.bit_x(1'b0, a);
    two_wire_host_i.stop();
    quiet();
    rd_seq(8'h01, 1);
    $display("test partial stop done");
    cmd(8'h6e, 1'b1);
    hx = 1'b1;
    check(half, 1'b1, "half set");
    wr_page(8'h10, 1, t2);
    rd_seq(8'h10, 1);
    hv = 1'b1;
    cmd(8'h6a, 1'b1);
    poll();
    cmd(8'h6a, 1'b0);
    setaddr(8'h10);
    send(8'h5a, 1'b0, "protected data");
    two_wire_host_i.stop();
    quiet();
    rd_seq(8'h10, 1);
    wr_page(8'h90, 1, t2);
    cmd(8'h60, 1'b1);
    poll();
    setaddr(8'h90);
    send(8'h5a, 1'b0, "protected data");
    two_wire_host_i.stop();
    quiet();
    cmd(8'h68, 1'b1);
    poll();
    cmd(8'h68, 1'b0);
    cmd(8'h62, 1'b1);
    poll();
    cmd(8'h62, 1'b0);
    cmd(8'h66, 1'b1);
    poll();
    wr_page(8'h10, 1, t2);
    rd_seq(8'h10, 1);
    hv = 1'b0;
    cmd(8'h6c, 1'b1);
    check(half, 1'b0, "half clear");
    hx = 1'b0;
    rd_seq(8'h00, 2);
    $display("test half and protect done");
    print_verdict();
  end

  initial
  begin
    #400000;
    failures++;
    print_verdict();
  end
endmodule
